// ---- inc/bio_pkg.sv ----
// Shared constants, types and address decode for the bidirectional I/O port block
package bio_pkg;

    // Geometry of the block
    localparam int NUM_PORTS = 3;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;
    localparam int PORT_IDX_W = 2;

    // Register map: control word, then three words per port
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PORT_BASE = 8'h01;
    localparam logic [7:0] PORT_STRIDE = 8'h03;
    localparam logic [7:0] OFS_PIN = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h01;
    localparam logic [7:0] OFS_OUT = 8'h02;

    // Control word field and reset values
    localparam int PUD_BIT = 4;
    localparam logic [7:0] RST_OUT = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic RST_PUD = 1'b0;
    localparam logic [7:0] RD_IDLE = 8'h00;
    localparam logic RST_SAMPLE_BIT = 1'b0;

    // Kind of location hit by an address
    typedef enum logic [1:0] {
        BIO_REG_NONE = 2'b00,
        BIO_REG_PIN = 2'b01,
        BIO_REG_DIR = 2'b10,
        BIO_REG_OUT = 2'b11
    } bio_reg_e;

    // Result of an address decode
    typedef struct packed {
        logic ctrl;
        bio_reg_e kind;
        logic [PORT_IDX_W-1:0] port;
    } bio_dec_s;

    // Register state of the port block
    typedef struct packed {
        logic [NUM_PORTS-1:0][PORT_W-1:0] outVal;
        logic [NUM_PORTS-1:0][PORT_W-1:0] dir;
        logic global_pullup_disable;
        logic [PORT_W-1:0] rdData;
    } bio_state_s;

    // Register state of one synchroniser
    typedef struct packed {
        logic [PORT_W-1:0] sample;
    } bio_sync_s;

    // Maps a register address onto control word or port location
    function automatic bio_dec_s bio_decode(input logic [ADDR_W-1:0] addr);
        bio_dec_s dec;
        logic [7:0] base;
        dec.ctrl = (addr == ADDR_CTRL);
        dec.kind = BIO_REG_NONE;
        dec.port = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            base = ADDR_PORT_BASE + 8'(p) * PORT_STRIDE;
            if (addr == base + OFS_PIN) begin
                dec.kind = BIO_REG_PIN;
                dec.port = PORT_IDX_W'(p);
            end
            if (addr == base + OFS_DIR) begin
                dec.kind = BIO_REG_DIR;
                dec.port = PORT_IDX_W'(p);
            end
            if (addr == base + OFS_OUT) begin
                dec.kind = BIO_REG_OUT;
                dec.port = PORT_IDX_W'(p);
            end
        end
        return dec;
    endfunction : bio_decode

endpackage : bio_pkg

// ---- inc/bio_sync_if.sv ----
// Link between the port register logic and one pin synchroniser
`timescale 1ns/1ps
`default_nettype none

interface bio_sync_if;
    logic [bio_pkg::PORT_W-1:0] padLevel;
    logic [bio_pkg::PORT_W-1:0] sample;

    // Register side hands pad levels over and takes samples back
    modport regs (
        output padLevel,
        input sample
    );

    // Synchroniser side
    modport sync (
        input padLevel,
        output sample
    );
endinterface : bio_sync_if

`default_nettype wire

// ---- hdl/bio_sync.sv ----
// Latch plus flop synchroniser for the pin levels of one port
`timescale 1ns/1ps
`default_nettype none

module bio_sync (
    input wire logic clk,
    input wire logic rst_n,
    bio_sync_if.sync link
);

    logic [bio_pkg::PORT_W-1:0] latchQ;
    bio_pkg::bio_sync_s q;
    bio_pkg::bio_sync_s d;

    // Open while clock high, holds while clock low
    always_latch begin
        if (clk) begin
            latchQ <= link.padLevel; // RULE13
        end
    end

    // Held level moves into the sample register
    always_comb begin
        d = q;
        d.sample = latchQ; // RULE12 RULE14
    end

    // Sample register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{sample: {bio_pkg::PORT_W{bio_pkg::RST_SAMPLE_BIT}}};
        end else begin
            q <= d; // RULE13
        end
    end

    assign link.sample = q.sample;

endmodule : bio_sync

`default_nettype wire

// ---- hdl/bio_port.sv ----
// Bidirectional general purpose I/O ports with register access
//
// Functional notes
// RULE1: Direction bit one enables the pin's output driver.
// RULE2: Direction bit zero makes the pin an input, driver off.
// RULE3: Input pin pulls up when output value one and global disable clear.
// RULE4: Pull-up is off when output value zero or pin is an output.
// RULE5: Output pin drives the output value bit, high or low.
// RULE6: Global pull-up disable turns off every pull-up in every port.
// RULE7: Reset holds every pin tri-stated without pull-up, clock or not.
// RULE8: Writing one to an input sample bit flips the output value bit.
// RULE9: Input sample location is read-only; value and direction read and write.
// RULE10: Each port has three locations: value, direction, input sample.
// RULE11: One pin's bits can change without touching other pins' bits.
// RULE12: Pin level readable through input sample via latch and flop.
// RULE13: Latch open while clock high, holds low, loads on rising edge.
// RULE14: Pin change seen after half to one and a half clock periods.
// RULE15: Software written level is readable one clock period after the write.
// RULE16: Software passes through an intermediate state when swapping modes.
// RULE17: Alternate function on some pins leaves the other pins usable.
// RULE18: Registers are eight bits, bit n is pin n, all reset to zero.
`timescale 1ns/1ps
`default_nettype none

module bio_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [bio_pkg::ADDR_W-1:0] regAddr,
    input wire logic [bio_pkg::PORT_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [bio_pkg::PORT_W-1:0] regRdData,
    input wire logic [bio_pkg::NUM_PORTS-1:0][bio_pkg::PORT_W-1:0] padIn,
    output logic [bio_pkg::NUM_PORTS-1:0][bio_pkg::PORT_W-1:0] padOut,
    output logic [bio_pkg::NUM_PORTS-1:0][bio_pkg::PORT_W-1:0] padOe_n,
    output logic [bio_pkg::NUM_PORTS-1:0][bio_pkg::PORT_W-1:0] padPullUp,
    input wire logic [bio_pkg::NUM_PORTS-1:0][bio_pkg::PORT_W-1:0] altEn,
    input wire logic [bio_pkg::NUM_PORTS-1:0][bio_pkg::PORT_W-1:0] altOe,
    input wire logic [bio_pkg::NUM_PORTS-1:0][bio_pkg::PORT_W-1:0] altVal
);

    // Register state and its next value
    bio_pkg::bio_state_s q;
    bio_pkg::bio_state_s d;

    // Decoded bus address
    bio_pkg::bio_dec_s dec;

    // Synchronised pin levels per port
    logic [bio_pkg::NUM_PORTS-1:0][bio_pkg::PORT_W-1:0] pinSample;

    // Effective per-pin drive after alternate overrides
    logic [bio_pkg::NUM_PORTS-1:0][bio_pkg::PORT_W-1:0] effOe;
    logic [bio_pkg::NUM_PORTS-1:0][bio_pkg::PORT_W-1:0] effVal;
    logic [bio_pkg::NUM_PORTS-1:0][bio_pkg::PORT_W-1:0] effPull;

    // Write and read qualifiers
    logic wrCtrl;
    logic wrPort;
    logic rdCtrl;
    logic rdPort;

    // Address decode shared by read and write paths
    always_comb begin
        dec = bio_pkg::bio_decode(regAddr); // RULE10
    end

    // Qualified strobes
    assign wrCtrl = regWr && dec.ctrl;
    assign wrPort = regWr && (dec.kind != bio_pkg::BIO_REG_NONE);
    assign rdCtrl = regRd && dec.ctrl;
    assign rdPort = regRd && (dec.kind != bio_pkg::BIO_REG_NONE);

    // Next register state from bus writes and reads
    always_comb begin
        d = q;
        d.rdData = bio_pkg::RD_IDLE;

        // Control word: only the pull-up disable bit is held
        if (wrCtrl) begin
            d.global_pullup_disable = regWrData[bio_pkg::PUD_BIT]; // RULE6
        end

        // Port locations, whole byte per write
        if (wrPort) begin
            unique case (dec.kind)
                bio_pkg::BIO_REG_PIN: begin
                    // Ones flip, zeros leave bits alone
                    d.outVal[dec.port] = q.outVal[dec.port] ^ regWrData; // RULE8 RULE11
                end
                bio_pkg::BIO_REG_DIR: begin
                    d.dir[dec.port] = regWrData; // RULE9 RULE11
                end
                bio_pkg::BIO_REG_OUT: begin
                    d.outVal[dec.port] = regWrData; // RULE9 RULE11
                end
                bio_pkg::BIO_REG_NONE: begin
                    d.outVal = q.outVal;
                end
            endcase
        end

        // Control word readback, other bits read zero
        if (rdCtrl) begin
            d.rdData[bio_pkg::PUD_BIT] = q.global_pullup_disable;
        end

        // Port readback
        if (rdPort) begin
            unique case (dec.kind)
                bio_pkg::BIO_REG_PIN: begin
                    d.rdData = pinSample[dec.port]; // RULE12 RULE15
                end
                bio_pkg::BIO_REG_DIR: begin
                    d.rdData = q.dir[dec.port]; // RULE9
                end
                bio_pkg::BIO_REG_OUT: begin
                    d.rdData = q.outVal[dec.port]; // RULE9
                end
                bio_pkg::BIO_REG_NONE: begin
                    d.rdData = bio_pkg::RD_IDLE;
                end
            endcase
        end
    end

    // State register, cleared by asynchronous reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.outVal <= {bio_pkg::NUM_PORTS{bio_pkg::RST_OUT}}; // RULE18
            q.dir <= {bio_pkg::NUM_PORTS{bio_pkg::RST_DIR}}; // RULE18
            q.global_pullup_disable <= bio_pkg::RST_PUD; // RULE18
            q.rdData <= bio_pkg::RD_IDLE;
        end else begin
            q <= d;
        end
    end

    // Read data stand only in the cycle after the read strobe
    assign regRdData = q.rdData;

    // Per-port pin logic and synchroniser
    for (genvar p = 0; p < bio_pkg::NUM_PORTS; p++) begin : g_port

        bio_sync_if syncLink ();

        // Pad level enters the synchroniser irrespective of direction
        assign syncLink.padLevel = padIn[p]; // RULE12
        assign pinSample[p] = syncLink.sample;

        bio_sync u_sync (
            .clk(clk),
            .rst_n(rst_n),
            .link(syncLink)
        );

        // Per-pin driver and pull-up control
        for (genvar n = 0; n < bio_pkg::PORT_W; n++) begin : g_pin

            // Overridden pins follow the alternate function alone
            assign effOe[p][n] = altEn[p][n] ? altOe[p][n] : q.dir[p][n]; // RULE1 RULE2 RULE17
            assign effVal[p][n] = altEn[p][n] ? altVal[p][n] : q.outVal[p][n]; // RULE5 RULE17

            // Pull-up only on a plain input with value one
            assign effPull[p][n] = !altEn[p][n]
                && !q.dir[p][n]
                && q.outVal[p][n]
                && !q.global_pullup_disable; // RULE3 RULE4 RULE6

            // Reset gates the pad combinationally, no clock needed
            assign padOe_n[p][n] = !(rst_n && effOe[p][n]); // RULE1 RULE2 RULE7
            assign padOut[p][n] = rst_n && effVal[p][n]; // RULE5 RULE7
            assign padPullUp[p][n] = rst_n && effPull[p][n]; // RULE7
        end
    end

endmodule : bio_port

`default_nettype wire

// ---- dv/bio_port_checker.sv ----
// Assertion checker on the ports of the I/O port block
`timescale 1ns/1ps
`default_nettype none
module bio_port_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic [2:0][7:0] padIn,
    input wire logic [2:0][7:0] padOut,
    input wire logic [2:0][7:0] padOe_n,
    input wire logic [2:0][7:0] padPullUp
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Pad controls and read data against bus traffic, port 0, control word and an unmapped address
    property p_pull_drv; (padPullUp & ~padOe_n) == '0; endproperty
    a_pull_drv: assert property (p_pull_drv) else $error("pull-up on a driven pin");
    property p_dir; regWr && regAddr == 8'h02 |=> padOe_n[0] == ~$past(regWrData); endproperty
    a_dir: assert property (p_dir) else $error("driver enable off direction");
    property p_out; regWr && regAddr == 8'h03 |=> padOut[0] == $past(regWrData); endproperty
    a_out: assert property (p_out) else $error("drive value wrong");
    property p_tog; regWr && regAddr == 8'h01 |=> padOut[0] == ($past(padOut[0]) ^ $past(regWrData)); endproperty
    a_tog: assert property (p_tog) else $error("toggle wrong");
    property p_pin_ro; regWr && regAddr == 8'h01 |=> $stable(padOe_n); endproperty
    a_pin_ro: assert property (p_pin_ro) else $error("sample write moved direction");
    property p_pud; regWr && regAddr == 8'h00 && regWrData[4] |=> padPullUp == '0; endproperty
    a_pud: assert property (p_pud) else $error("pull-up left on");
    property p_sync; regRd && regAddr == 8'h01 && $past(rst_n) |=> regRdData == $past(padIn[0], 2); endproperty
    a_sync: assert property (p_sync) else $error("sample delay wrong");
    property p_unmap; regRd && regAddr == 8'h0a |=> regRdData == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule : bio_port_checker
bind bio_port bio_port_checker u_bio_port_checker (.clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .padIn, .padOut, .padOe_n, .padPullUp);
`default_nettype wire

// ---- dv/bio_pad_model.sv ----
// External circuitry at the pads: drivers, pull-ups, floating lines
`timescale 1ns/1ps
`default_nettype none
module bio_pad_model (
    input wire logic clk,
    input wire logic [2:0][7:0] padOut,
    input wire logic [2:0][7:0] padOe_n,
    input wire logic [2:0][7:0] padPullUp,
    input wire logic [2:0][7:0] extEn,
    input wire logic [2:0][7:0] extVal,
    output logic [2:0][7:0] pad
);
    logic [2:0][7:0] floatQ = '0;
    // Undriven lines without pull-up wander every cycle
    always @(posedge clk) floatQ <= ~floatQ;
    // Device driver first, then external driver, then pull-up
    assign pad = (~padOe_n & padOut) | (padOe_n & extEn & extVal) | (padOe_n & ~extEn & (padPullUp | floatQ));
endmodule : bio_pad_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the I/O port block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef logic [2:0][7:0] bio_pins_t;
    logic clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, rdPend = 1'b0, pudM = 1'b0;
    logic [7:0] regAddr = '0, regWrData = '0, regRdData, rdExp = '0, nxtExp = '0, e;
    bio_pins_t padIn, padOut, padOe_n, padPullUp, altEn = '0, altOe = '0, altVal = '0, extEn = '1, extVal = '0;
    bio_pins_t outM = '0, dirM = '0;
    int n_errors = 0, check_count = 0, cyc = 0, p;
    always #2 clk = ~clk;
    bio_port u_bio_port (.clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .padIn, .padOut,
        .padOe_n, .padPullUp, .altEn, .altOe, .altVal);
    bio_pad_model u_bio_pad_model (.clk, .padOut, .padOe_n, .padPullUp, .extEn, .extVal, .pad(padIn));
    // Compare and count
    task automatic chk(input logic [23:0] s, input logic [23:0] x);
        check_count++;
        if (s !== x) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic stop_test();
        if (n_errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    // Read data check one cycle after strobe, and hang guard
    always @(posedge clk) begin
        if (rdPend) chk(regRdData, rdExp);
        rdPend <= regRd;
        rdExp <= nxtExp;
        cyc++;
        if (cyc == 4000) begin
            n_errors++;
            stop_test();
        end
    end
    // Reference model of registers and pins
    function automatic logic [7:0] regExp(input int a);
        for (int i = 0; i < 3; i++) begin
            if (a == 3 * i + 1) return dirM[i] & outM[i] | ~dirM[i] & (extEn[i] & extVal[i] | ~extEn[i] & outM[i] & {8{~pudM}});
            if (a == 3 * i + 2) return dirM[i];
            if (a == 3 * i + 3) return outM[i];
        end
        return a == 0 ? {3'h0, pudM, 4'h0} : 8'h00;
    endfunction : regExp
    task automatic bus(input logic w, input logic r, input int a, input logic [7:0] d, input logic [7:0] x);
        regWr <= w;
        regRd <= r;
        regAddr <= 8'(a);
        regWrData <= d;
        nxtExp <= x;
        @(posedge clk);
    endtask : bus
    task automatic wr(input int a, input logic [7:0] d);
        for (int i = 0; i < 3; i++) begin
            if (a == 3 * i + 1) outM[i] ^= d;
            if (a == 3 * i + 2) dirM[i] = d;
            if (a == 3 * i + 3) outM[i] = d;
        end
        if (a == 0) pudM = d[4];
        bus(1'b1, 1'b0, a, d, 8'h00);
    endtask : wr
    task automatic rd(input int a);
        bus(1'b0, 1'b1, a, 8'h00, regExp(a));
    endtask : rd
    task automatic idle();
        bus(1'b0, 1'b0, 0, 8'h00, 8'h00);
    endtask : idle
    // Pads against model, and tri-state in reset
    task automatic chkPads();
        chk(padOe_n, ~(altEn & altOe | ~altEn & dirM));
        chk(padOut, altEn & altVal | ~altEn & outM);
        chk(padPullUp, ~altEn & ~dirM & outM & {24{~pudM}});
    endtask : chkPads
    task automatic rstChk();
        chk(padOe_n, '1);
        chk(padPullUp, '0);
        chk(padOut, '0);
    endtask : rstChk
    // Main sequence
    initial begin
        void'($urandom(23));
        #1 rstChk();
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (p = 0; p < 11; p++) rd(p);
        for (p = 0; p < 3; p++) begin
            wr(3 * p + 2, 8'($urandom));
            wr(3 * p + 3, 8'($urandom));
            wr(3 * p + 1, 8'h01 << p);
            rd(3 * p + 2);
            rd(3 * p + 3);
        end
        idle();
        chkPads();
        extVal <= bio_pins_t'($urandom);
        idle();
        idle();
        for (p = 0; p < 3; p++) rd(3 * p + 1);
        e = regExp(1);
        wr(3, ~outM[0]);
        bus(1'b0, 1'b1, 1, 8'h00, e);
        rd(1);
        extEn <= '0;
        wr(5, 8'h00);
        wr(6, 8'hff);
        idle();
        chkPads();
        idle();
        rd(4);
        wr(0, 8'hff);
        idle();
        chkPads();
        rd(0);
        wr(0, 8'h00);
        wr(10, 8'($urandom));
        altEn[2] <= 8'h0f;
        altOe[2] <= 8'($urandom);
        altVal[2] <= 8'($urandom);
        idle();
        chkPads();
        #1 rst_n = 1'b0;
        #1 rstChk();
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        outM = '0;
        dirM = '0;
        @(posedge clk);
        rd(2);
        idle();
        chkPads();
        idle();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
